// ===== icrb_pkg.sv
// icrb_pkg: constants and carrier types for the indexed configuration register bank.
// assumes a single core clock domain; all ports except the asynchronous reset are synchronous to it.
package icrb_pkg;

  // i/o port addresses
  localparam logic [15:0] ICRB_PORT_INDEX = 16'h0022;
  localparam logic [15:0] ICRB_PORT_DATA  = 16'h0023;

  // register indices
  localparam logic [7:0] ICRB_IDX_PERF    = 8'h20;
  localparam logic [7:0] ICRB_IDX_SMMACC  = 8'hC1;
  localparam logic [7:0] ICRB_IDX_CACHE   = 8'hC2;
  localparam logic [7:0] ICRB_IDX_MAP     = 8'hC3;
  localparam logic [7:0] ICRB_IDX_SMM_REGION_ADDRESS_HI = 8'hCD;
  localparam logic [7:0] ICRB_IDX_SMM_REGION_ADDRESS_MD = 8'hCE;
  localparam logic [7:0] ICRB_IDX_SMM_REGION_ADDRESS_LO = 8'hCF;
  localparam logic [7:0] ICRB_IDX_IORC    = 8'hE8;
  localparam logic [7:0] ICRB_IDX_PMR     = 8'hF0;
  localparam logic [7:0] ICRB_IDX_ID0     = 8'hFE;
  localparam logic [7:0] ICRB_IDX_ID1     = 8'hFF;
  localparam logic [7:0] ICRB_RANGE_LO    = 8'hC0;
  localparam logic [7:0] ICRB_RANGE_HI    = 8'hCF;

  // map-enable field
  localparam int          ICRB_EXTENDED_MAP_ENABLE_LSB  = 4;
  localparam logic [3:0]  ICRB_EXTENDED_MAP_ENABLE_OPEN = 4'h1;

  // writable-bit masks (reserved bits read zero) and the lock-protected map-control bit
  localparam logic [7:0] ICRB_MASK_PERF   = 8'h87;
  localparam logic [7:0] ICRB_MASK_SMMACC = 8'h0E;
  localparam logic [7:0] ICRB_MASK_CACHE  = 8'hDE;
  localparam logic [7:0] ICRB_MASK_IORC   = 8'h1F;
  localparam logic [7:0] ICRB_MASK_PMR    = 8'h07;
  localparam logic [7:0] ICRB_LOCKED_MAP  = 8'h02;

  // field positions
  localparam int ICRB_BIT_RSTK     = 0;
  localparam int ICRB_BIT_BTB      = 1;
  localparam int ICRB_BIT_LOOP     = 2;
  localparam int ICRB_BIT_SERIAL   = 7;
  localparam int ICRB_BIT_MGMT_EN  = 1;
  localparam int ICRB_BIT_MSPACE   = 2;
  localparam int ICRB_BIT_MAINRED  = 3;
  localparam int ICRB_BIT_WB_EN    = 1;
  localparam int ICRB_BIT_NWLOCK   = 2;
  localparam int ICRB_BIT_SUSPHALT = 3;
  localparam int ICRB_BIT_LOWWT    = 4;
  localparam int ICRB_BIT_BURSTWR  = 6;
  localparam int ICRB_BIT_SUSPEND_REQUEST_INPUT_EN  = 7;
  localparam int ICRB_BIT_LOCK     = 0;
  localparam int ICRB_BIT_NMI      = 1;
  localparam int ICRB_BIT_LINBURST = 2;
  localparam int ICRB_BIT_PINDEF   = 3;

  // reset values
  localparam logic [7:0] ICRB_RST_ZERO = 8'h00;
  localparam logic [7:0] ICRB_RST_IORC = 8'h05;
  localparam logic [7:0] ICRB_RST_PMR  = 8'h01;

  // i/o cycle request from the core
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] port;
    logic [7:0]  wdata;
  } icrb_io_req_t;

  // decoded control outputs
  typedef struct packed {
    logic return_predict_enable;
    logic branch_predict_enable;
    logic loop_keep_prefetch;
    logic access_serialize;
    logic mgmt_pins_enable;
    logic mgmt_space_access;
    logic main_space_redirect;
    logic writeback_pins_enable;
    logic nowrite_bit_lock;
    logic suspend_after_halt;
    logic low_region_writethrough;
    logic burst_write_enable;
    logic suspend_pins_enable;
    logic mgmt_register_lock;
    logic nmi_in_mgmt_enable;
    logic linear_burst_order;
    logic mgmt_pin_definition;
  } icrb_ctrl_t;

endpackage

// ===== icrb_bank.sv
// icrb_bank: indexed configuration register bank reached through i/o ports 22h/23h.
// assumes the core presents one i/o cycle per valid pulse and takes claim/rdata next cycle.
// Notes on behaviour
// - index written to port 22h selects a register; port 23h moves its data
// - only first port 23h access after an index write is claimed; later ones go external
// - indices outside C0h-CFh and FEh-FFh go external unless map-enable opens them
// - map-enable 0001 also claims indices 20h, E8h and F0h
// - map-enable bits 7-4; 1h opens 20h, E8h and F0h and traps port 22h; 0h only base set
// - perf bit0 return prediction, bit1 branch prediction, bit2 keep prefetch on jump
// - perf bit7 serialises memory accesses; 640K-1M region always in order
// - smm access bit1 enables management interrupt pin and strobe, else ignored/floating
// - smm access bit2 sends smm-space accesses external with strobe, interrupt ignored
// - smm access bit3 redirects handler data accesses to main memory
// - reset clears smm access bits 1-3; other bits reserved
// - cache bit1 enables write-back pins; clear ignores inputs and floats outputs
// - cache bit1 must precede no-write bit; cache bit2 blocks no-write changes
// - cache bit3 suspends after halt; bit7 enables suspend request and acknowledge pins
// - cache bit4 makes cache-hit writes in 640K-1M also go to the external bus
// - cache bit6 allows 16-byte burst write-back cycles
// - reset clears cache bits 1-4, 6 and 7; bits 0 and 5 reserved
// - lock bit blocks non-handler writes to smm bits; only reset clears it
// - map control bit1 lets nmi be recognised in management mode
// - map control bit2 picks linear burst order, else interleaved order
// - map control bit3 picks alternate management pin definition
`timescale 1ns/1ns
module icrb_bank
  import icrb_pkg::*;
#(
  parameter logic [7:0] DEVICE_ID_VALUE = 8'h5A, // arbitrary identity value
  parameter logic [7:0] STEPPING_VALUE  = 8'h11  // arbitrary stepping/revision value
) (
  // clock and reset
  input  wire logic         clk_sys_in,
  input  wire logic         rst_n_in,
  // i/o cycle from the core
  input  wire icrb_io_req_t io_req_in,
  input  wire logic         in_mgmt_handler_in,
  // core-side requests to gate
  input  wire logic         nowrite_change_req_in,
  input  wire logic         nowrite_value_in,
  input  wire logic         mgmt_interrupt_pin_in,
  input  wire logic         invalidate_input_in,
  input  wire logic         warm_reset_input_in,
  input  wire logic         suspend_request_input_in,
  // answers to the core
  output logic              claim_out,
  output logic              external_out,
  output logic [7:0]        rdata_out,
  output icrb_ctrl_t        ctrl_out,
  output logic [3:0]        extended_map_enable_out,
  output logic [7:0]        smm_region_address_out [3],
  output logic [7:0]        io_recovery_control_out,
  output logic [7:0]        power_clock_control_out,
  // gated pin qualifiers
  output logic              cache_nowrite_bit_out,
  output logic              mgmt_interrupt_seen_out,
  output logic              mgmt_pin_oe_out,
  output logic              writeback_in_seen_out,
  output logic              writeback_pin_oe_out,
  output logic              suspend_request_seen_out,
  output logic              suspend_ack_oe_out
);

  logic [7:0] index_sel;
  logic       index_fresh;
  logic [7:0] perf_feature_control;
  logic [7:0] smm_access_control;
  logic [7:0] cache_suspend_control;
  logic [7:0] smm_map_control;
  logic [7:0] smm_region_address [3];
  logic [7:0] io_recovery_control;
  logic [7:0] power_clock_control;
  logic       cache_nowrite_bit;

  logic       is_index_port;
  logic       is_data_port;
  logic       map_open;
  logic       base_hit;
  logic       ext_hit;
  logic       reg_hit;
  logic       data_claim;
  logic       index_claim;
  logic       smm_wr_ok;
  logic       wr_go;
  logic [7:0] next_rdata;

  assign is_index_port = io_req_in.valid && io_req_in.port == ICRB_PORT_INDEX;
  assign is_data_port  = io_req_in.valid && io_req_in.port == ICRB_PORT_DATA;
  assign map_open = smm_map_control[ICRB_EXTENDED_MAP_ENABLE_LSB +: 4] == ICRB_EXTENDED_MAP_ENABLE_OPEN;
  // base set is always reachable; extended set only while the map is open
  assign base_hit = (index_sel >= ICRB_RANGE_LO && index_sel <= ICRB_RANGE_HI)
                    || index_sel == ICRB_IDX_ID0 || index_sel == ICRB_IDX_ID1;
  assign ext_hit  = map_open && (index_sel == ICRB_IDX_PERF || index_sel == ICRB_IDX_IORC
                    || index_sel == ICRB_IDX_PMR);
  assign reg_hit  = base_hit || ext_hit;
  // a data access is ours only once per index write
  assign data_claim  = is_data_port && index_fresh && reg_hit;
  // index port writes are always latched, but the port is only trapped while the map is open
  assign index_claim = is_index_port && map_open;
  assign wr_go       = data_claim && io_req_in.write;
  // lock shields smm bits except inside the handler
  assign smm_wr_ok = !smm_map_control[ICRB_BIT_LOCK] || in_mgmt_handler_in;

  // index capture and one-shot data window
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      index_sel   <= ICRB_RST_ZERO;
      index_fresh <= 1'b0;
    end else if (is_index_port && io_req_in.write) begin
      index_sel   <= io_req_in.wdata;
      index_fresh <= 1'b1;
    end else if (is_data_port) begin
      index_fresh <= 1'b0; // any port 23h access spends the index
    end
  end

  // performance, recovery and clock registers (extended set)
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      perf_feature_control <= ICRB_RST_ZERO;
      io_recovery_control  <= ICRB_RST_IORC;
      power_clock_control  <= ICRB_RST_PMR;
    end else if (wr_go) begin
      if (index_sel == ICRB_IDX_PERF) begin
        perf_feature_control <= io_req_in.wdata & ICRB_MASK_PERF;
      end else if (index_sel == ICRB_IDX_IORC) begin
        io_recovery_control <= io_req_in.wdata & ICRB_MASK_IORC;
      end else if (index_sel == ICRB_IDX_PMR) begin
        power_clock_control <= io_req_in.wdata & ICRB_MASK_PMR;
      end
    end
  end

  // smm access control, lock-protected
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      smm_access_control <= ICRB_RST_ZERO;
    end else if (wr_go && index_sel == ICRB_IDX_SMMACC && smm_wr_ok) begin
      smm_access_control <= io_req_in.wdata & ICRB_MASK_SMMACC;
    end
  end

  // cache and suspend control
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cache_suspend_control <= ICRB_RST_ZERO;
    end else if (wr_go && index_sel == ICRB_IDX_CACHE) begin
      cache_suspend_control <= io_req_in.wdata & ICRB_MASK_CACHE;
    end
  end

  // map control: lock bit is sticky until reset, nmi bit lock-protected
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      smm_map_control <= ICRB_RST_ZERO;
    end else if (wr_go && index_sel == ICRB_IDX_MAP) begin
      smm_map_control <= smm_wr_ok ? io_req_in.wdata
                       : ((io_req_in.wdata & ~ICRB_LOCKED_MAP)
                          | (smm_map_control & ICRB_LOCKED_MAP));
      if (smm_map_control[ICRB_BIT_LOCK]) begin
        smm_map_control[ICRB_BIT_LOCK] <= 1'b1; // only reset clears the lock
      end
    end
  end

  // smm region address bytes, lock-protected
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      smm_region_address[0] <= ICRB_RST_ZERO;
      smm_region_address[1] <= ICRB_RST_ZERO;
      smm_region_address[2] <= ICRB_RST_ZERO;
    end else if (wr_go && smm_wr_ok) begin
      if (index_sel == ICRB_IDX_SMM_REGION_ADDRESS_HI) begin
        smm_region_address[0] <= io_req_in.wdata;
      end else if (index_sel == ICRB_IDX_SMM_REGION_ADDRESS_MD) begin
        smm_region_address[1] <= io_req_in.wdata;
      end else if (index_sel == ICRB_IDX_SMM_REGION_ADDRESS_LO) begin
        smm_region_address[2] <= io_req_in.wdata;
      end
    end
  end

  // no-write bit of the core control register, frozen while locked
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cache_nowrite_bit <= 1'b0;
    end else if (nowrite_change_req_in && !cache_suspend_control[ICRB_BIT_NWLOCK]) begin
      cache_nowrite_bit <= nowrite_value_in;
    end
  end

  // read mux; unmapped base-range indices read zero
  always_comb begin
    next_rdata = ICRB_RST_ZERO;
    if (index_sel == ICRB_IDX_PERF) begin
      next_rdata = perf_feature_control;
    end else if (index_sel == ICRB_IDX_SMMACC) begin
      next_rdata = smm_access_control;
    end else if (index_sel == ICRB_IDX_CACHE) begin
      next_rdata = cache_suspend_control;
    end else if (index_sel == ICRB_IDX_MAP) begin
      next_rdata = smm_map_control;
    end else if (index_sel == ICRB_IDX_SMM_REGION_ADDRESS_HI) begin
      next_rdata = smm_region_address[0];
    end else if (index_sel == ICRB_IDX_SMM_REGION_ADDRESS_MD) begin
      next_rdata = smm_region_address[1];
    end else if (index_sel == ICRB_IDX_SMM_REGION_ADDRESS_LO) begin
      next_rdata = smm_region_address[2];
    end else if (index_sel == ICRB_IDX_IORC) begin
      next_rdata = io_recovery_control;
    end else if (index_sel == ICRB_IDX_PMR) begin
      next_rdata = power_clock_control;
    end else if (index_sel == ICRB_IDX_ID0) begin
      next_rdata = DEVICE_ID_VALUE;
    end else if (index_sel == ICRB_IDX_ID1) begin
      next_rdata = STEPPING_VALUE;
    end
  end

  // cycle answer, one cycle after the request
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      claim_out    <= 1'b0;
      external_out <= 1'b0;
      rdata_out    <= ICRB_RST_ZERO;
    end else begin
      claim_out    <= data_claim || index_claim;
      // non-claimed port 22h/23h cycles go to the external bus
      external_out <= (is_data_port && !data_claim) || (is_index_port && !map_open);
      rdata_out    <= (data_claim && !io_req_in.write) ? next_rdata : ICRB_RST_ZERO;
    end
  end

  // registered control and pin qualifiers; registered for clean timing
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_out                 <= '0;
      extended_map_enable_out  <= 4'h0;
      smm_region_address_out   <= '{default: ICRB_RST_ZERO};
      io_recovery_control_out  <= ICRB_RST_IORC;
      power_clock_control_out  <= ICRB_RST_PMR;
      cache_nowrite_bit_out    <= 1'b0;
      mgmt_interrupt_seen_out  <= 1'b0;
      mgmt_pin_oe_out          <= 1'b0;
      writeback_in_seen_out    <= 1'b0;
      writeback_pin_oe_out     <= 1'b0;
      suspend_request_seen_out <= 1'b0;
      suspend_ack_oe_out       <= 1'b0;
    end else begin
      ctrl_out.return_predict_enable   <= perf_feature_control[ICRB_BIT_RSTK];
      ctrl_out.branch_predict_enable   <= perf_feature_control[ICRB_BIT_BTB];
      ctrl_out.loop_keep_prefetch      <= perf_feature_control[ICRB_BIT_LOOP];
      ctrl_out.access_serialize        <= perf_feature_control[ICRB_BIT_SERIAL];
      ctrl_out.mgmt_pins_enable        <= smm_access_control[ICRB_BIT_MGMT_EN];
      ctrl_out.mgmt_space_access       <= smm_access_control[ICRB_BIT_MSPACE];
      ctrl_out.main_space_redirect     <= smm_access_control[ICRB_BIT_MAINRED];
      ctrl_out.writeback_pins_enable   <= cache_suspend_control[ICRB_BIT_WB_EN];
      ctrl_out.nowrite_bit_lock        <= cache_suspend_control[ICRB_BIT_NWLOCK];
      ctrl_out.suspend_after_halt      <= cache_suspend_control[ICRB_BIT_SUSPHALT];
      ctrl_out.low_region_writethrough <= cache_suspend_control[ICRB_BIT_LOWWT];
      ctrl_out.burst_write_enable      <= cache_suspend_control[ICRB_BIT_BURSTWR];
      ctrl_out.suspend_pins_enable     <= cache_suspend_control[ICRB_BIT_SUSPEND_REQUEST_INPUT_EN];
      ctrl_out.mgmt_register_lock      <= smm_map_control[ICRB_BIT_LOCK];
      ctrl_out.nmi_in_mgmt_enable      <= smm_map_control[ICRB_BIT_NMI];
      ctrl_out.linear_burst_order      <= smm_map_control[ICRB_BIT_LINBURST];
      ctrl_out.mgmt_pin_definition     <= smm_map_control[ICRB_BIT_PINDEF];
      extended_map_enable_out  <= smm_map_control[ICRB_EXTENDED_MAP_ENABLE_LSB +: 4];
      smm_region_address_out   <= smm_region_address;
      io_recovery_control_out  <= io_recovery_control;
      power_clock_control_out  <= power_clock_control;
      cache_nowrite_bit_out    <= cache_nowrite_bit;
      // interrupt input ignored when pins disabled or smm space forced external
      mgmt_interrupt_seen_out  <= mgmt_interrupt_pin_in
                                  && smm_access_control[ICRB_BIT_MGMT_EN]
                                  && !smm_access_control[ICRB_BIT_MSPACE];
      mgmt_pin_oe_out          <= smm_access_control[ICRB_BIT_MGMT_EN];
      writeback_in_seen_out    <= (invalidate_input_in || warm_reset_input_in)
                                  && cache_suspend_control[ICRB_BIT_WB_EN];
      writeback_pin_oe_out     <= cache_suspend_control[ICRB_BIT_WB_EN];
      suspend_request_seen_out <= suspend_request_input_in
                                  && cache_suspend_control[ICRB_BIT_SUSPEND_REQUEST_INPUT_EN];
      suspend_ack_oe_out       <= cache_suspend_control[ICRB_BIT_SUSPEND_REQUEST_INPUT_EN];
    end
  end

endmodule

// ===== icrb_bank_asserts.sv
// icrb_bank_asserts: port-level checks for the indexed configuration register bank.
// assumes it is bound onto icrb_bank; one clock domain, async active-low reset.
`timescale 1ns/1ns
module icrb_bank_asserts
  import icrb_pkg::*;
(
  // clock and reset
  input wire logic         clk_sys_in,
  input wire logic         rst_n_in,
  // watched ports
  input wire icrb_io_req_t io_req_in,
  input wire icrb_ctrl_t   ctrl_out,
  input wire logic         claim_out,
  input wire logic         external_out,
  input wire logic [3:0]   extended_map_enable_out,
  input wire logic         mgmt_interrupt_seen_out,
  input wire logic         writeback_pin_oe_out,
  input wire logic         suspend_ack_oe_out,
  input wire logic         cache_nowrite_bit_out
);
  logic       spent;
  logic [7:0] idx;
  logic       base_hit;
  logic       ext_hit;

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  // index tracker: a data access spends the index, an index write renews it
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      spent <= 1'b1;
      idx   <= 8'h00;
    end else if (io_req_in.valid && io_req_in.write && io_req_in.port == ICRB_PORT_INDEX) begin
      spent <= 1'b0;
      idx   <= io_req_in.wdata;
    end else if (io_req_in.valid && io_req_in.port == ICRB_PORT_DATA) begin
      spent <= 1'b1;
    end
  end

  // decode classes of the held index
  assign base_hit = (idx >= 8'hC0 && idx <= 8'hCF) || idx >= 8'hFE;
  assign ext_hit  = idx == 8'h20 || idx == 8'hE8 || idx == 8'hF0;

  // the map field output lags its register by one cycle, so it is read one cycle
  // after the request; there it shows the value that the decode used
  sequence s_map_field(v);
    extended_map_enable_out == v;
  endsequence
  sequence s_data_req;
    io_req_in.valid && io_req_in.port == ICRB_PORT_DATA;
  endsequence
  sequence s_index_req;
    io_req_in.valid && io_req_in.port == ICRB_PORT_INDEX;
  endsequence

  a_answer_exclusive: assert property (!(claim_out && external_out))
    else $error("claim and external raised together");
  a_stale_data_ext: assert property (s_data_req ##0 spent |=> external_out && !claim_out)
    else $error("data access without fresh index was not sent out");
  a_unmapped_ext: assert property (s_data_req ##0 (!spent && !base_hit) ##1
      s_map_field(4'h0) |-> external_out && !claim_out)
    else $error("index outside base set was claimed with map closed");
  a_extended_claim: assert property (s_data_req ##0 (!spent && ext_hit) ##1
      s_map_field(ICRB_EXTENDED_MAP_ENABLE_OPEN) |-> claim_out && !external_out)
    else $error("extended register not claimed with map open");
  a_index_trap: assert property (s_index_req ##1
      s_map_field(ICRB_EXTENDED_MAP_ENABLE_OPEN) |-> claim_out)
    else $error("index port not trapped with map open");
  a_index_pass: assert property (s_index_req ##1
      s_map_field(4'h0) |-> external_out)
    else $error("index port not sent out with map closed");
  a_mgmt_gate: assert property ($stable(ctrl_out.mgmt_pins_enable) &&
      $stable(ctrl_out.mgmt_space_access) &&
      !(ctrl_out.mgmt_pins_enable && !ctrl_out.mgmt_space_access) |-> !mgmt_interrupt_seen_out)
    else $error("management interrupt seen while gated off");
  a_wb_pin_oe: assert property ($stable(ctrl_out.writeback_pins_enable) |->
      writeback_pin_oe_out == ctrl_out.writeback_pins_enable)
    else $error("write-back pin enable disagrees with control bit");
  a_suspend_request_input_pin_oe: assert property ($stable(ctrl_out.suspend_pins_enable) |->
      suspend_ack_oe_out == ctrl_out.suspend_pins_enable)
    else $error("suspend pin enable disagrees with control bit");
  a_nowrite_hold: assert property (ctrl_out.nowrite_bit_lock ##1 ctrl_out.nowrite_bit_lock
      |-> $stable(cache_nowrite_bit_out))
    else $error("no-write bit changed while locked");
  a_lock_sticky: assert property (ctrl_out.mgmt_register_lock |=> ctrl_out.mgmt_register_lock)
    else $error("register lock cleared without reset");
endmodule

// ===== icrb_bank_tb.sv
// icrb_bank_tb: self-checking bench for the indexed configuration register bank.
// assumes package and checker compiled first; inputs change on falling clock edges.
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module icrb_bank_tb
  import icrb_pkg::*;
;
  localparam logic [7:0] ID_V   = 8'h3C; // arbitrary identity value
  localparam logic [7:0] STEP_V = 8'h42; // arbitrary stepping value
  logic clk_sys_in, rst_n_in, in_mgmt_handler_in, nowrite_change_req_in, nowrite_value_in;
  logic mgmt_interrupt_pin_in, invalidate_input_in, warm_reset_input_in;
  logic suspend_request_input_in, claim_out, external_out, cache_nowrite_bit_out;
  logic mgmt_interrupt_seen_out, mgmt_pin_oe_out, writeback_in_seen_out, writeback_pin_oe_out;
  logic suspend_request_seen_out, suspend_ack_oe_out, nw_exp;
  logic [7:0] rdata_out, io_recovery_control_out, power_clock_control_out;
  logic [7:0] smm_region_address_out [3];
  logic [3:0] extended_map_enable_out;
  icrb_io_req_t io_req_in;
  icrb_ctrl_t   ctrl_out;
  int failures, total_checks, cyc;
  logic [7:0] sh [256];
  logic [7:0] b_idx [8] = '{8'hC1, 8'hC2, 8'hC3, 8'hCD, 8'hCE, 8'hCF, 8'hFE, 8'hFF};
  logic [7:0] r_msk [6] = '{8'h0E, 8'hDE, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0] x_idx [3] = '{8'h20, 8'hE8, 8'hF0};
  logic [7:0] x_msk [3] = '{8'h87, 8'h1F, 8'h07};

  icrb_bank #(.DEVICE_ID_VALUE(ID_V), .STEPPING_VALUE(STEP_V)) i_icrb_bank (
    .clk_sys_in, .rst_n_in, .io_req_in, .in_mgmt_handler_in, .nowrite_change_req_in,
    .nowrite_value_in, .mgmt_interrupt_pin_in, .invalidate_input_in, .warm_reset_input_in,
    .suspend_request_input_in, .claim_out, .external_out, .rdata_out, .ctrl_out,
    .extended_map_enable_out, .smm_region_address_out, .io_recovery_control_out,
    .power_clock_control_out, .cache_nowrite_bit_out, .mgmt_interrupt_seen_out,
    .mgmt_pin_oe_out, .writeback_in_seen_out, .writeback_pin_oe_out,
    .suspend_request_seen_out, .suspend_ack_oe_out);

  // 25 MHz core clock
  always #20 clk_sys_in = ~clk_sys_in;

  // hang guard; a normal run needs well under two thousand cycles
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // one i/o cycle; answer sampled in the following cycle, valid left for the caller
  task automatic io(input logic w, input logic [15:0] p, input logic [7:0] d);
    io_req_in = '{1'b1, w, p, d};
    @(negedge clk_sys_in);
  endtask

  task automatic wr(input logic [7:0] i, d, m, input logic c);
    io(1'b1, ICRB_PORT_INDEX, i);
    io(1'b1, ICRB_PORT_DATA, d);
    `CHK(claim_out, c)
    sh[i] = (sh[i] & ~m) | (d & m);
  endtask

  task automatic rd(input logic [7:0] i);
    io(1'b1, ICRB_PORT_INDEX, i);
    io(1'b0, ICRB_PORT_DATA, 8'h00);
    `CHK({claim_out, rdata_out}, {1'b1, sh[i]})
  endtask

  function automatic icrb_ctrl_t exp_ctrl();
    logic [7:0] p, a, c, m;
    p = sh[8'h20];
    a = sh[8'hC1];
    c = sh[8'hC2];
    m = sh[8'hC3];
    return '{p[0], p[1], p[2], p[7], a[1], a[2], a[3], c[1], c[2], c[3], c[4], c[6], c[7],
             m[0], m[1], m[2], m[3]};
  endfunction

  // idle three cycles with random pins and a no-write request, then compare every control, register and pin output
  task automatic settle();
    io_req_in.valid = 1'b0;
    {mgmt_interrupt_pin_in, invalidate_input_in, warm_reset_input_in,
     suspend_request_input_in, nowrite_value_in} = 5'($urandom);
    nowrite_change_req_in = 1'b1;
    if (!sh[8'hC2][2]) nw_exp = nowrite_value_in;
    @(negedge clk_sys_in);
    nowrite_change_req_in = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    `CHK(ctrl_out, exp_ctrl())
    `CHK({extended_map_enable_out, io_recovery_control_out, power_clock_control_out},
         {sh[8'hC3][7:4], sh[8'hE8], sh[8'hF0]})
    `CHK({smm_region_address_out[0], smm_region_address_out[1], smm_region_address_out[2]},
         {sh[8'hCD], sh[8'hCE], sh[8'hCF]})
    `CHK(mgmt_interrupt_seen_out, mgmt_interrupt_pin_in & sh[8'hC1][1] & ~sh[8'hC1][2])
    `CHK({mgmt_pin_oe_out, writeback_pin_oe_out, suspend_ack_oe_out},
         {sh[8'hC1][1], sh[8'hC2][1], sh[8'hC2][7]})
    `CHK({writeback_in_seen_out, suspend_request_seen_out},
         {(invalidate_input_in | warm_reset_input_in) & sh[8'hC2][1],
          suspend_request_input_in & sh[8'hC2][7]})
    `CHK(cache_nowrite_bit_out, nw_exp)
  endtask

  task automatic do_reset();
    rst_n_in = 1'b0;
    repeat (16) @(negedge clk_sys_in);
    sh = '{default: 8'h00};
    sh[8'hE8] = 8'h05;
    sh[8'hF0] = 8'h01;
    sh[8'hFE] = ID_V;
    sh[8'hFF] = STEP_V;
    nw_exp = 1'b0;
    rst_n_in = 1'b1;
  endtask

  // main sequence
  initial begin
    int k;
    logic [7:0] x, d, m;
    logic old;
    void'($urandom(32'h92C8142B));
    {clk_sys_in, in_mgmt_handler_in, nowrite_change_req_in, nowrite_value_in} = 4'h0;
    {mgmt_interrupt_pin_in, invalidate_input_in, warm_reset_input_in} = 3'h0;
    {suspend_request_input_in, failures, total_checks, cyc} = '0;
    io_req_in = '0;
    do_reset();
    settle();
    for (k = 0; k < 8; k++) rd(b_idx[k]);
    // map closed: extended and foreign indices go out on both ports
    for (k = 0; k < 12; k++) begin
      x = x_idx[k % 3];
      if (k >= 3) do x = 8'($urandom); while ((x >= 8'hC0 && x <= 8'hCF) || x >= 8'hFE);
      io(1'b1, ICRB_PORT_INDEX, x);
      `CHK(external_out, 1'b1)
      io(1'b0, ICRB_PORT_DATA, 8'h00);
      `CHK({claim_out, external_out}, 2'b01)
    end
    // second data access on a spent index
    rd(8'hC2);
    io(1'b0, ICRB_PORT_DATA, 8'h00);
    `CHK({claim_out, external_out}, 2'b01)
    // random register traffic with handler and lock; reset in mid-run
    for (int n = 0; n < 60; n++) begin
      if (n == 30) do_reset();
      k = $urandom_range(0, 5);
      in_mgmt_handler_in = 1'($urandom);
      d = 8'($urandom) & ((k == 2) ? 8'h0F : 8'hFF);
      m = r_msk[k];
      old = sh[8'hC3][0];
      if (old && !in_mgmt_handler_in) m = (k == 2) ? 8'hFD : ((k == 1) ? m : 8'h00);
      wr(b_idx[k], d, m, 1'b1);
      if (k == 2) sh[8'hC3][0] = old | d[0];
      rd(b_idx[k]);
      settle();
    end
    // map open: index port trapped, extended registers reachable
    wr(8'hC3, {4'h1, sh[8'hC3][3:0]}, 8'hF0, 1'b1);
    settle();
    io(1'b0, ICRB_PORT_INDEX, 8'h00);
    `CHK({claim_out, external_out}, 2'b10)
    for (k = 0; k < 3; k++) begin
      wr(x_idx[k], 8'($urandom), x_msk[k], 1'b1);
      rd(x_idx[k]);
      settle();
    end
    // back to normal operation with the map closed
    wr(8'hC3, {4'h0, sh[8'hC3][3:0]}, 8'hF0, 1'b1);
    io(1'b1, ICRB_PORT_INDEX, 8'hC3);
    `CHK(external_out, 1'b1)
    settle();
    give_verdict();
  end
endmodule

bind icrb_bank icrb_bank_asserts i_icrb_bank_asserts (.clk_sys_in, .rst_n_in, .io_req_in,
  .ctrl_out, .claim_out, .external_out, .extended_map_enable_out, .mgmt_interrupt_seen_out,
  .writeback_pin_oe_out, .suspend_ack_oe_out, .cache_nowrite_bit_out);
